// *** src/ccac_cluster.sv ***
`timescale 1ns/1ps
`include "ccac_params.svh"


module ccac_cluster
#(
	parameter int ELEMENTS = `CCAC_ELEMENTS,
	parameter int ROW_CLOCKS = `CCAC_ROW_CLOCKS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// cluster-wide controls
	input wire logic add_sub_select,
	input wire logic cluster_carry_in,
	input wire logic cluster_aclr,
	// row clock lines
	input wire logic [ROW_CLOCKS-1:0] cluster_row_clock,
	input wire logic [`CCAC_ROW_SEL_W-1:0] row_clock_sel,
	// element configuration
	input wire logic [ELEMENTS-1:0] elem_mode,
	input wire logic [ELEMENTS*`CCAC_LUT_W-1:0] lut_mask,
	input wire logic [ELEMENTS-1:0] lut_chain_en,
	input wire logic [ELEMENTS-1:0] reg_chain_en,
	input wire logic [ELEMENTS-1:0] route_sel,
	// element data from local routing
	input wire logic [ELEMENTS-1:0] data_a,
	input wire logic [ELEMENTS-1:0] data_b,
	input wire logic [ELEMENTS-1:0] data_c,
	input wire logic [ELEMENTS-1:0] data_d,
	// chain inputs from the cluster above
	input wire logic lut_chain_in,
	input wire logic reg_chain_in,
	// routing outputs
	output logic [ELEMENTS-1:0] route_comb_q,
	output logic [ELEMENTS-1:0] elem_reg_q,
	output logic [ELEMENTS-1:0] route_mix_q,
	// chain outputs to the cluster below
	output logic lut_chain_out_q,
	output logic reg_chain_out,
	output logic cluster_carry_out_q
);

	// ==========================================================
	// row clock selection
	// row lines come from outside this clock, so three stages
	logic [ROW_CLOCKS-1:0] row_s1_q;
	logic [ROW_CLOCKS-1:0] row_s2_q;
	logic [ROW_CLOCKS-1:0] row_s3_q;
	logic [ROW_CLOCKS-1:0] row_lvl_q;
	logic [ROW_CLOCKS-1:0] row_rise;
	logic tick;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			row_s1_q <= '0;
			row_s2_q <= '0;
			row_s3_q <= '0;
		end
		else
		begin
			row_s1_q <= cluster_row_clock;
			row_s2_q <= row_s1_q;
			row_s3_q <= row_s2_q;
		end
	end

	// level moves only when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (srst)
			row_lvl_q <= '0;
		else
			row_lvl_q <= (row_s2_q & row_s3_q)
				| (row_lvl_q & (row_s2_q | row_s3_q));
	end

	assign row_rise = row_s2_q & row_s3_q & ~row_lvl_q;
	assign tick = row_rise[row_clock_sel];

	// ==========================================================
	// elements and chains
	logic [ELEMENTS:0] carry_zero;
	logic [ELEMENTS:0] carry_one;
	logic [ELEMENTS:0] lut_link;
	logic [ELEMENTS:0] reg_link;
	logic [ELEMENTS-1:0] comb;
	logic [ELEMENTS-1:0] elem_d;

	// element zero holds the lsb and gets the select as its carry
	assign carry_zero[0] = add_sub_select ? `CCAC_SUB_CARRY
		: `CCAC_ADD_CARRY;
	assign carry_one[0] = `CCAC_ONE_CHAIN_CARRY;
	// chain ends enter from the cluster above and leave to the cluster below
	assign lut_link[0] = lut_chain_in;
	assign reg_link[0] = reg_chain_in;
	assign reg_link[ELEMENTS:1] = elem_reg_q;

	genvar k;
	generate
		for (k = 0; k < ELEMENTS; k++)
		begin : g_elem
			ccac_element u_element
			(
				.data_a(data_a[k]),
				.data_b(data_b[k]),
				.data_c(data_c[k]),
				.data_d(data_d[k]),
				.add_sub_select(add_sub_select),
				.cluster_carry_in(cluster_carry_in),
				.carry_input_zero(carry_zero[k]),
				.carry_input_one(carry_one[k]),
				.lut_chain_in(lut_link[k]),
				.mode(ccac_pkg::ccac_mode_t'(elem_mode[k])),
				.lut_chain_en(lut_chain_en[k]),
				.lut_mask(lut_mask[k*`CCAC_LUT_W +: `CCAC_LUT_W]),
				.comb_out(comb[k]),
				.carry_output_zero(carry_zero[k+1]),
				.carry_output_one(carry_one[k+1])
			);
			assign lut_link[k+1] = comb[k];
			// register source: own lookup or the register above
			assign elem_d[k] = reg_chain_en[k] ? reg_link[k]
				: comb[k];
		end
	endgenerate

	// ==========================================================
	// element registers
	// shared clear acts without the clock; the cost is a reset
	// path that is asynchronous to clk in every element
	always_ff @(posedge clk or posedge cluster_aclr)
	begin
		if (cluster_aclr)
			elem_reg_q <= {ELEMENTS{`CCAC_REG_CLEAR}};
		else if (srst)
			elem_reg_q <= {ELEMENTS{`CCAC_REG_CLEAR}};
		else if (tick)
			elem_reg_q <= elem_d;
	end

	assign reg_chain_out = elem_reg_q[ELEMENTS-1];

	// ==========================================================
	// routing outputs
	// unregistered results are retimed once so every port is a flop
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			route_comb_q <= '0;
			route_mix_q <= '0;
		end
		else
		begin
			route_comb_q <= comb;
			route_mix_q <= (route_sel & elem_reg_q)
				| (~route_sel & comb);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			lut_chain_out_q <= 1'b0;
			cluster_carry_out_q <= 1'b0;
		end
		else
		begin
			lut_chain_out_q <= lut_link[ELEMENTS];
			cluster_carry_out_q <= cluster_carry_in
				? carry_one[ELEMENTS] : carry_zero[ELEMENTS];
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || cluster_aclr);

	logic carry_ref;
	assign carry_ref = (data_a[0] & (data_b[0] ^ add_sub_select))
		| ((data_a[0] ^ data_b[0] ^ add_sub_select)
		& add_sub_select);

	// subtract in element zero: inverted b plus a forced carry of one
	// leaves a xor b as the sum and a or not b as the carry out
	lsb_carry_a: assert property (
		add_sub_select && elem_mode[0] && !cluster_carry_in
		|-> comb[0] == (data_a[0] ^ data_b[0])
		&& carry_zero[1] == (data_a[0] | !data_b[0]))
		else $error("element zero carry does not follow select");

	sub_invert_a: assert property (
		carry_zero[1] == carry_ref)
		else $error("element zero carry out wrong for add or sub");

	add_plain_a: assert property (
		!add_sub_select && elem_mode[0] && !cluster_carry_in
		|-> comb[0] == (data_a[0] ^ data_b[0]))
		else $error("element zero sum wrong during addition");

	lut_chain_a: assert property (
		lut_chain_en[1] && !elem_mode[1]
		|-> comb[1] == lut_mask[`CCAC_LUT_W +
		{data_d[1], data_c[1], data_b[1], comb[0]}])
		else $error("lookup chain not feeding element one");

	sequence shift_step;
		tick && reg_chain_en[1];
	endsequence

	shift_chain_a: assert property (
		shift_step ##1 !cluster_aclr
		|-> elem_reg_q[1] == $past(elem_reg_q[0]))
		else $error("register chain did not shift");

	reg_hold_a: assert property (
		!tick ##1 !cluster_aclr |-> $stable(elem_reg_q))
		else $error("element register moved without row edge");

	comb_route_a: assert property (
		##1 route_comb_q == $past(comb))
		else $error("unregistered route lost lookup result");

	sequence row_up;
		row_s2_q[row_clock_sel] && row_s3_q[row_clock_sel]
			&& !row_lvl_q[row_clock_sel];
	endsequence

	row_edge_a: assert property (
		row_up |-> tick ##1 row_lvl_q[$past(row_clock_sel)])
		else $error("row clock edge not taken");

	clear_zero_a: assert property (
		@(posedge clk) disable iff (srst)
		cluster_aclr |-> elem_reg_q == '0)
		else $error("clear left an element register set");

endmodule : ccac_cluster

// *** src/ccac_params.svh ***
`ifndef CCAC_PARAMS_SVH
`define CCAC_PARAMS_SVH

// ==========================================================
// cluster geometry
`define CCAC_ELEMENTS 10
`define CCAC_LUT_W 16
`define CCAC_LUT_SEL_W 4
`define CCAC_ROW_CLOCKS 8
`define CCAC_ROW_SEL_W 3

// ==========================================================
// carry and clear constants
`define CCAC_ADD_CARRY 1'b0
`define CCAC_SUB_CARRY 1'b1
`define CCAC_ONE_CHAIN_CARRY 1'b1
`define CCAC_REG_CLEAR 1'b0

`endif

// *** src/ccac_pkg.sv ***
package ccac_pkg;

	// ==========================================================
	// element operating mode
	typedef enum logic [0:0]
	{
		CCAC_MODE_NORMAL = 1'b0,
		CCAC_MODE_ARITH = 1'b1
	} ccac_mode_t;

endpackage : ccac_pkg

// *** src/ccac_element.sv ***
`timescale 1ns/1ps
`include "ccac_params.svh"

module ccac_element
(
	// local routing data
	input wire logic data_a,
	input wire logic data_b,
	input wire logic data_c,
	input wire logic data_d,
	// cluster-wide and chain inputs
	input wire logic add_sub_select,
	input wire logic cluster_carry_in,
	input wire logic carry_input_zero,
	input wire logic carry_input_one,
	input wire logic lut_chain_in,
	// configuration
	input wire ccac_pkg::ccac_mode_t mode,
	input wire logic lut_chain_en,
	input wire logic [`CCAC_LUT_W-1:0] lut_mask,
	// results
	output logic comb_out,
	output logic carry_output_zero,
	output logic carry_output_one
);

	// ==========================================================
	// helpers
	function automatic logic maj3(input logic x, input logic y,
		input logic z);
	begin
		maj3 = (x & y) | (x & z) | (y & z);
	end
	endfunction : maj3

	function automatic logic lut_pick(
		input logic [`CCAC_LUT_W-1:0] mask,
		input logic [`CCAC_LUT_SEL_W-1:0] sel);
	begin
		lut_pick = mask[sel];
	end
	endfunction : lut_pick

	// ==========================================================
	// datapath
	logic b_eff;
	logic first_in;
	logic carry_sel;

	// subtraction inverts b inside the cluster
	assign b_eff = data_b ^ add_sub_select;
	// fast chain input replaces data_a, no local routing used
	assign first_in = lut_chain_en ? lut_chain_in : data_a;
	assign carry_sel = cluster_carry_in ? carry_input_one
		: carry_input_zero;

	always_comb
	begin
		case (mode)
			ccac_pkg::CCAC_MODE_ARITH:
				comb_out = data_a ^ b_eff ^ carry_sel;
			ccac_pkg::CCAC_MODE_NORMAL:
				comb_out = lut_pick(lut_mask,
					{data_d, data_c, data_b, first_in});
			default:
				comb_out = lut_pick(lut_mask,
					{data_d, data_c, data_b, first_in});
		endcase
	end

	// both carry-select chains ripple to the next element
	assign carry_output_zero = maj3(data_a, b_eff, carry_input_zero);
	assign carry_output_one = maj3(data_a, b_eff, carry_input_one);

endmodule : ccac_element

// *** testbench/ccac_neighbour.sv ***
`timescale 1ns/1ps
// ====
// upstream neighbour: row clock source and register chain feed
module ccac_neighbour
(
	// clock
	input wire logic clk,
	// bench requests
	input wire logic fire,
	input wire logic [2:0] line,
	input wire logic feed,
	// toward the cluster
	output logic [7:0] cluster_row_clock,
	output logic reg_chain_in
);
	logic [2:0] hold_q = 3'h0;
	logic feed_q = 1'b0;
	// four cycles high clears the sync filter; the bench waits long after
	always @(posedge clk)
	begin
		hold_q <= fire ? 3'h4 : hold_q - 3'(hold_q != 3'h0);
		if (fire)
			feed_q <= feed;
	end
	assign reg_chain_in = feed_q;
	always_comb
	begin
		cluster_row_clock = 8'h00;
		cluster_row_clock[line] = hold_q != 3'h0;
	end
endmodule : ccac_neighbour

// *** testbench/test_cluster_addsub_chain.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end

module test_cluster_addsub_chain;
	logic clk = 0, srst = 1, sub = 0, cci = 0, aclr = 0, fire = 0, feed = 0;
	logic lci = 0;
	logic [2:0] rsel = 0;
	logic [9:0] mode = 0, lce = 0, rce = 0, rts = 0;
	logic [9:0] da = 0, db = 0, dc = 0, dd = 0, exp_q = 0;
	logic [10:0] e;
	logic [159:0] mask = {10{16'h6996}};
	logic [7:0] rowclk;
	logic rci, lco, rco, cco;
	logic [9:0] comb, regq, mix;
	int fails = 0, total_checks = 0;

	always #4 clk = ~clk;

	ccac_neighbour ccac_neighbour_i (.clk(clk), .fire(fire), .line(rsel),
		.feed(feed), .cluster_row_clock(rowclk), .reg_chain_in(rci));

	ccac_cluster ccac_cluster_i (.clk(clk), .srst(srst),
		.add_sub_select(sub), .cluster_carry_in(cci), .cluster_aclr(aclr),
		.cluster_row_clock(rowclk), .row_clock_sel(rsel), .elem_mode(mode),
		.lut_mask(mask), .lut_chain_en(lce), .reg_chain_en(rce),
		.route_sel(rts), .data_a(da), .data_b(db), .data_c(dc), .data_d(dd),
		.lut_chain_in(lci), .reg_chain_in(rci), .route_comb_q(comb),
		.elem_reg_q(regq), .route_mix_q(mix), .lut_chain_out_q(lco),
		.reg_chain_out(rco), .cluster_carry_out_q(cco));

	// ====
	// expectations
	function automatic logic [10:0] arith(logic [9:0] a, b, logic s, c);
		return {1'b0, a} + {1'b0, s ? ~b : b} + {10'h000, s | c};
	endfunction : arith

	function automatic logic [9:0] chain(logic [9:0] b, c, d, logic i);
		logic [9:0] r;
		for (int k = 0; k < 10; k++)
		begin
			i = i ^ b[k] ^ c[k] ^ d[k];
			r[k] = i;
		end
		return r;
	endfunction : chain

	// ====
	// tasks
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task add_sub(logic [9:0] a, b, logic s, c);
		@(posedge clk);
		da <= a;
		db <= b;
		sub <= s;
		cci <= c;
		settle;
		e = arith(a, b, s, c);
		`CHK(comb, e[9:0])
		`CHK(cco, e[10])
		`CHK(mix, e[9:0])
	endtask : add_sub

	task shift(logic f);
		@(posedge clk);
		fire <= 1'b1;
		feed <= f;
		db <= 10'($urandom);
		@(posedge clk);
		fire <= 1'b0;
		repeat (12) @(posedge clk);
		#1;
		exp_q = {exp_q[8:0], f};
		`CHK(regq, exp_q)
		`CHK(rco, exp_q[9])
		`CHK(mix, exp_q)
		`CHK(comb, da ^ db ^ dc ^ dd)
	endtask : shift

	task report_and_stop;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop;
	end

	// ====
	// main sequence
	initial
	begin
		void'($urandom(32'h33bf_9cb6));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		mode <= {10{ccac_pkg::CCAC_MODE_ARITH}};
		settle;
		`CHK(regq, 10'h000)
		add_sub(10'h3ff, 10'h001, 1'b0, 1'b0);
		add_sub(10'h000, 10'h001, 1'b1, 1'b0);
		add_sub(10'h2aa, 10'h2aa, 1'b1, 1'b0);
		add_sub(10'h155, 10'h0aa, 1'b0, 1'b1);
		repeat (40)
			add_sub(10'($urandom), 10'($urandom), 1'($urandom), 1'($urandom));
		// normal mode: same mask, all four data inputs reach the lookup
		@(posedge clk);
		mode <= 10'h000;
		repeat (20)
		begin
			@(posedge clk);
			{da, db, dc, dd} <= 40'($urandom) ^ {40'($urandom) << 8};
			settle;
			`CHK(comb, da ^ db ^ dc ^ dd)
		end
		@(posedge clk);
		lce <= 10'h3ff;
		repeat (20)
		begin
			@(posedge clk);
			{db, dc, dd} <= 30'($urandom);
			lci <= 1'($urandom);
			settle;
			e[9:0] = chain(db, dc, dd, lci);
			`CHK(comb, e[9:0])
			`CHK(lco, e[9])
		end
		@(posedge clk);
		lce <= 10'h000;
		rce <= 10'h3ff;
		rts <= 10'h3ff;
		for (int l = 0; l < 8; l++)
		begin
			@(posedge clk);
			rsel <= 3'(l);
			repeat (3)
				shift(1'($urandom));
		end
		shift(1'b1);
		@(posedge clk);
		aclr <= 1'b1;
		#1;
		`CHK(regq, 10'h000)
		@(posedge clk);
		aclr <= 1'b0;
		exp_q = 10'h000;
		shift(1'b1);
		report_and_stop;
	end
endmodule : test_cluster_addsub_chain
